// >>> mace_core_model.sv
/* processor core model issuing register reads and writes.
   assumes the bench calls wr and rd after reset release. */
`timescale 1ns/1ps
`include "mace_map.svh"

// ----------------------------------------------------------------------
// core bus master
// ----------------------------------------------------------------------
module mace_core_model (
    // clock
    input  wire logic       clk,
    // register access
    output logic [7:0]      sfr_addr,
    output logic            sfr_wr,
    output logic [7:0]      sfr_wdata,
    output logic            sfr_rd,
    input  wire logic [7:0] sfr_rdata,
    input  wire logic       busy
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd = 1'b0;
    end

    // guarded registers wait for the pipeline to drain
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        if (a == `MACE_ADDR_CONFIG || a == `MACE_ADDR_STATUS
            || (a >= `MACE_ADDR_ACC0 && a <= `MACE_ADDR_GUARD)) begin
            @(negedge clk);
            while (busy && n < 20) begin
                @(negedge clk);
                n++;
            end
            if (busy) begin
                mace_engine_test.err_count++;
                $display("MISMATCH busy before write expected 0 seen %b", busy);
                mace_engine_test.final_report();
            end
        end
        // two edges between writes keep clear of stage one
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        sfr_addr <= ~a;
        @(posedge clk);
        @(negedge clk);
        d = sfr_rdata;
    endtask
endmodule

// >>> mace_engine.sv
/*
 * mace_engine.sv
 * signed 16x16 multiply-accumulate engine with 40-bit accumulator,
 * one-bit accumulator shifter and a rounding and saturation stage,
 * reached through byte-wide special function register accesses.
 * assumes sfr_wr and sfr_rd are one-cycle strobes synchronous to clk
 * and that software keeps off registers during the early pipe stages.
 */
// How it works
// - rounded result comes from acc bits 31-16, unbiased rounding on the low half.
// - low half above 0x8000 rounds up, below rounds down, equal rounds to even.
// - rounding updates in stage three, after a shift, and on acc byte 0 write.
// - rounding never changes the accumulator; only rounding registers get it.
// - integer mode updates rounding registers the same as fractional mode.
// - with saturation on, overflow loads 0x7FFF or 0x8000; off, never saturates.
// - config bit 5 shifts the 40-bit accumulator next cycle, then self-clears.
// - config bit 4 zero shifts left, one shifts right.
// - config bit 3 clears accumulator and status next cycle, then self-clears.
// - config bit 2 enables rounding saturation only, never touches the accumulator.
// - config bit 1 picks signed integer (0) or signed fractional (1) operands.
// - config bit 0 picks multiply-accumulate (0) or multiply only (1).
// - config bits 7-6 read zero and ignore writes.
// - sticky hard overflow when guard byte crosses 0x7F/0x80 in a MAC; sw zero clears.
// - zero flag follows whether the operation left the accumulator at zero.
// - soft overflow flag follows overflow into accumulator bit 31.
// - negative flag follows the sign of the accumulator result.
// - status bits 7-4 read zero and ignore writes.
// - writing operand B low byte starts the selected operation.
// - accumulator shows as guard byte 39-32 then bytes 31-24, 23-16, 15-8, 7-0.
// - stage one multiplies, stage two adds into the accumulator and sets flags.
// - multiply only adds to zero and leaves hard overflow alone.
// - right shift fills bit 39 with itself; shifts leave flags alone.
// - fractional operands are Q15, accumulator point sits between bits 31 and 30.
`timescale 1ns/1ps
`include "mace_map.svh"

module mace_engine (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // special function register access
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output logic [7:0]      sfr_rdata,
    // engine state
    output logic            busy
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    mace_pkg::mace_state_t st_r;
    mace_pkg::mace_state_t st_nxt;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    logic [7:0]  byte_addr [5];
    logic [4:0]  acc_byte_wr;
    logic        wr_status;
    logic        wr_config;
    logic        wr_opa_lo;
    logic        wr_opa_hi;
    logic        wr_opb_lo;
    logic        wr_opb_hi;

    assign byte_addr[0] = `MACE_ADDR_ACC0;
    assign byte_addr[1] = `MACE_ADDR_ACC1;
    assign byte_addr[2] = `MACE_ADDR_ACC2;
    assign byte_addr[3] = `MACE_ADDR_ACC3;
    assign byte_addr[4] = `MACE_ADDR_GUARD;

    // per-byte accumulator write strobes
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_acc_wr
            assign acc_byte_wr[gi] = sfr_wr && (sfr_addr == byte_addr[gi]);
        end
    endgenerate

    assign wr_status = sfr_wr && (sfr_addr == `MACE_ADDR_STATUS);
    assign wr_config = sfr_wr && (sfr_addr == `MACE_ADDR_CONFIG);
    assign wr_opa_lo = sfr_wr && (sfr_addr == `MACE_ADDR_OPA_LOW);
    assign wr_opa_hi = sfr_wr && (sfr_addr == `MACE_ADDR_OPA_HIGH);
    assign wr_opb_lo = sfr_wr && (sfr_addr == `MACE_ADDR_OPB_LOW);
    assign wr_opb_hi = sfr_wr && (sfr_addr == `MACE_ADDR_OPB_HIGH);

    // ------------------------------------------------------------------
    // stage one: signed multiply
    // ------------------------------------------------------------------
    logic signed [31:0] prod_s;

    assign prod_s = $signed(st_r.opa) * $signed(st_r.opb);

    // ------------------------------------------------------------------
    // stage two: accumulate
    // ------------------------------------------------------------------
    logic [39:0] prod_ext;
    logic [39:0] acc_base;
    logic [39:0] acc_sum;
    logic        do_clear;
    logic        hard_cross;

    assign do_clear = st_r.cfg[`MACE_CF_CLEAR];

    always_comb begin
        // fractional keeps Q30 product as Q31 in the accumulator
        if (st_r.fm_2) begin
            prod_ext = {{7{st_r.prod[31]}}, st_r.prod, 1'b0};
        end else begin
            prod_ext = {{8{st_r.prod[31]}}, st_r.prod};
        end
    end

    assign acc_base = (st_r.ms_2 || do_clear) ? 40'h0 : st_r.acc;
    assign acc_sum  = acc_base + prod_ext;

    // guard byte passing 0x7F<->0x80
    assign hard_cross = ((acc_base[39:32] == `MACE_GUARD_POS_MAX) &&
                         (acc_sum[39:32] == `MACE_GUARD_NEG_MIN)) ||
                        ((acc_base[39:32] == `MACE_GUARD_NEG_MIN) &&
                         (acc_sum[39:32] == `MACE_GUARD_POS_MAX));

    // ------------------------------------------------------------------
    // shifter
    // ------------------------------------------------------------------
    logic [39:0] acc_shifted;

    always_comb begin
        if (st_r.cfg[`MACE_CF_SHIFT_DIR]) begin
            acc_shifted = {st_r.acc[39], st_r.acc[39:1]};
        end else begin
            acc_shifted = {st_r.acc[38:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // rounding and saturation
    // ------------------------------------------------------------------
    logic        round_up;
    logic [23:0] rnd_full;
    logic        rnd_ovf;
    logic [15:0] rnd_val;

    always_comb begin
        if (st_r.acc[15:0] > `MACE_ROUND_HALF) begin
            round_up = 1'b1;
        end else if (st_r.acc[15:0] == `MACE_ROUND_HALF) begin
            round_up = st_r.acc[16];
        end else begin
            round_up = 1'b0;
        end
    end

    // rounding reads acc only, never writes it back
    assign rnd_full = st_r.acc[39:16] + {23'h0, round_up};
    assign rnd_ovf  = (rnd_full[23:15] != {9{rnd_full[23]}});

    always_comb begin
        if (st_r.cfg[`MACE_CF_SAT] && rnd_ovf) begin
            rnd_val = rnd_full[23] ? `MACE_SAT_NEG : `MACE_SAT_POS;
        end else begin
            rnd_val = rnd_full[15:0];
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;

    always_comb begin
        unique case (sfr_addr)
            `MACE_ADDR_STATUS:   rd_mux = {4'h0, st_r.sta};
            `MACE_ADDR_CONFIG:   rd_mux = {2'h0, st_r.cfg};
            `MACE_ADDR_OPA_LOW:  rd_mux = st_r.opa[7:0];
            `MACE_ADDR_OPA_HIGH: rd_mux = st_r.opa[15:8];
            `MACE_ADDR_OPB_LOW:  rd_mux = st_r.opb[7:0];
            `MACE_ADDR_OPB_HIGH: rd_mux = st_r.opb[15:8];
            `MACE_ADDR_ACC0:     rd_mux = st_r.acc[7:0];
            `MACE_ADDR_ACC1:     rd_mux = st_r.acc[15:8];
            `MACE_ADDR_ACC2:     rd_mux = st_r.acc[23:16];
            `MACE_ADDR_ACC3:     rd_mux = st_r.acc[31:24];
            `MACE_ADDR_GUARD:    rd_mux = st_r.acc[39:32];
            `MACE_ADDR_RND_LOW:  rd_mux = st_r.rnd[7:0];
            `MACE_ADDR_RND_HIGH: rd_mux = st_r.rnd[15:8];
            default:             rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;

        // read data capture
        if (sfr_rd) begin
            st_nxt.rdata = rd_mux;
        end

        // configuration writes; top two bits dropped
        if (wr_config) begin
            st_nxt.cfg = sfr_wdata[5:0];
        end

        // operand bytes
        if (wr_opa_lo) begin
            st_nxt.opa[7:0] = sfr_wdata;
        end
        if (wr_opa_hi) begin
            st_nxt.opa[15:8] = sfr_wdata;
        end
        if (wr_opb_hi) begin
            st_nxt.opb[15:8] = sfr_wdata;
        end

        // operand b low byte starts an operation
        st_nxt.st1 = 1'b0;
        if (wr_opb_lo) begin
            st_nxt.opb[7:0] = sfr_wdata;
            st_nxt.st1      = 1'b1;
            st_nxt.ms_1     = st_r.cfg[`MACE_CF_MUL_ONLY];
            st_nxt.fm_1     = st_r.cfg[`MACE_CF_FRAC];
        end

        // stage one: product registered
        st_nxt.st2 = st_r.st1;
        if (st_r.st1) begin
            st_nxt.prod = prod_s;
            st_nxt.ms_2 = st_r.ms_1;
            st_nxt.fm_2 = st_r.fm_1;
        end

        // status writes by software; upper nibble ignored
        if (wr_status) begin
            st_nxt.sta = sfr_wdata[3:0];
        end

        // accumulator byte writes
        for (int i = 0; i < 5; i++) begin
            if (acc_byte_wr[i]) begin
                st_nxt.acc[i*8 +: 8] = sfr_wdata;
            end
        end

        // accumulator clear, self-clearing
        if (do_clear) begin
            st_nxt.acc                     = 40'h0;
            st_nxt.sta                     = `MACE_ST_CLEARED;
            st_nxt.cfg[`MACE_CF_CLEAR]     = 1'b0;
        end

        // one-bit shift, self-clearing, flags untouched
        if (st_r.cfg[`MACE_CF_SHIFT_TRIG]) begin
            st_nxt.acc                      = acc_shifted;
            st_nxt.cfg[`MACE_CF_SHIFT_TRIG] = 1'b0;
        end

        // stage two: accumulate and set flags
        if (st_r.st2) begin
            st_nxt.acc                   = acc_sum;
            st_nxt.sta[`MACE_ST_ZERO]    = (acc_sum == 40'h0);
            st_nxt.sta[`MACE_ST_NEG]     = acc_sum[39];
            st_nxt.sta[`MACE_ST_SOFT_OVF] = (acc_sum[39:31] != {9{acc_sum[39]}});
            if (!st_r.ms_2 && hard_cross) begin
                st_nxt.sta[`MACE_ST_HARD_OVF] = 1'b1;
            end else if (st_r.ms_2) begin
                st_nxt.sta[`MACE_ST_HARD_OVF] = do_clear ? 1'b0 :
                    (wr_status ? sfr_wdata[`MACE_ST_HARD_OVF] :
                     st_r.sta[`MACE_ST_HARD_OVF]);
            end
        end

        // rounding: stage three, after a shift, after byte 0 write
        if (st_r.rnd_pend) begin
            st_nxt.rnd = rnd_val;
        end
        st_nxt.rnd_pend = st_r.st2 || st_r.cfg[`MACE_CF_SHIFT_TRIG] ||
                          acc_byte_wr[0];
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r          <= '0;
            st_r.cfg      <= 6'(`MACE_CF_RESET & `MACE_CF_MASK);
            st_r.sta      <= 4'(`MACE_ST_RESET & `MACE_ST_MASK);
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign sfr_rdata = st_r.rdata;
    assign busy      = st_r.st1 || st_r.st2 || st_r.rnd_pend ||
                       st_r.cfg[`MACE_CF_SHIFT_TRIG] || st_r.cfg[`MACE_CF_CLEAR];

endmodule

// >>> mace_engine_props.sv
/* port assertions of the multiply-accumulate engine.
   assumes one clock and an asynchronous active-low reset. */
`timescale 1ns/1ps
`include "mace_map.svh"

// ----------------------------------------------------------------------
// port checker
// ----------------------------------------------------------------------
module mace_engine_props (
    // clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // register access
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_rdata,
    input wire logic       busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic op_go  = sfr_wr && (sfr_addr == `MACE_ADDR_OPB_LOW);
    wire logic cfg_wr = sfr_wr && (sfr_addr == `MACE_ADDR_CONFIG);

    AST_OP_SPAN: assert property (op_go |=> busy [*3])
        else $error("busy not held through the pipeline");
    AST_OP_DONE: assert property (op_go && !busy |-> ##[4:12] !busy)
        else $error("operation never finished");
    AST_SHIFT_BUSY: assert property (cfg_wr && sfr_wdata[5] |=> busy [*2])
        else $error("shift not started");
    AST_SHIFT_DONE: assert property (cfg_wr && sfr_wdata[5] && !busy |-> ##[2:6] !busy)
        else $error("shift never finished");
    AST_CLEAR_BUSY: assert property (cfg_wr && sfr_wdata[3] |=> busy)
        else $error("clear not started");
    AST_CFG_TOP: assert property (sfr_rd && sfr_addr == `MACE_ADDR_CONFIG |-> ##2 sfr_rdata[7:6] == 2'b00)
        else $error("config top bits not zero");
    AST_STA_TOP: assert property (sfr_rd && sfr_addr == `MACE_ADDR_STATUS |-> ##2 sfr_rdata[7:4] == 4'h0)
        else $error("status top bits not zero");
    AST_RD_HOLD: assert property (!sfr_rd && !$past(sfr_rd) |=> $stable(sfr_rdata))
        else $error("read data changed without a read");

    cover property (op_go);
    cover property (cfg_wr && sfr_wdata[5]);
    cover property (cfg_wr && sfr_wdata[3]);
endmodule

bind mace_engine mace_engine_props mace_engine_props_inst (
    .clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .busy(busy));

// >>> mace_engine_test.sv
/* self-checking bench of the multiply-accumulate engine.
   assumes mace_core_model drives the register bus. */
`timescale 1ns/1ps
`include "mace_map.svh"

module mace_engine_test;
    logic        clk;
    logic        reset_n;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic [7:0]  sfr_rdata;
    logic        sfr_wr;
    logic        sfr_rd;
    logic        busy;
    logic [39:0] m_acc;
    logic [3:0]  m_sta;
    logic [15:0] m_rnd;
    logic        m_sat;
    logic [31:0] seed;
    logic [40:0] rt [0:6];
    logic [15:0] a;
    logic [15:0] b;
    logic [7:0]  c;
    int          err_count;
    int          cmp_count;

    mace_engine mace_engine_inst (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_rdata(sfr_rdata), .busy(busy));
    mace_core_model mace_core_model_inst (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // random and expectation functions
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [15:0] f_rnd(input logic [39:0] v, input logic sat);
        logic [23:0] r;
        r = v[39:16] + 24'((v[15:0] > 16'h8000) || (v[15:0] == 16'h8000 && v[16]));
        if (sat && r[23:15] != {9{r[23]}})
            return r[23] ? 16'h8000 : 16'h7FFF;
        return r[15:0];
    endfunction

    // ------------------------------------------------------------------
    // bench tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic rdchk(input string what, input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] got;
        mace_core_model_inst.rd(ad, got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        mace_core_model_inst.wr(ad, d);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        if (n >= 40) begin
            err_count++;
            $display("MISMATCH busy expected 0 seen %b", busy);
            final_report();
        end
    endtask

    task automatic check_all(input bit with_rnd);
        for (int i = 0; i < 5; i++)
            rdchk("accumulator byte", `MACE_ADDR_ACC0 + 8'(i), m_acc[8*i+:8]);
        rdchk("status", `MACE_ADDR_STATUS, {4'h0, m_sta});
        if (with_rnd) begin
            rdchk("rounding low", `MACE_ADDR_RND_LOW, m_rnd[7:0]);
            rdchk("rounding high", `MACE_ADDR_RND_HIGH, m_rnd[15:8]);
        end
    endtask

    task automatic set_cfg(input logic [7:0] v);
        wr(`MACE_ADDR_CONFIG, v);
        m_sat = v[2];
    endtask

    task automatic set_acc(input logic [39:0] v);
        for (int i = 4; i >= 0; i--)
            wr(`MACE_ADDR_ACC0 + 8'(i), v[8*i+:8]);
        m_acc = v;
        m_rnd = f_rnd(v, m_sat);
    endtask

    task automatic step(input logic [15:0] x, input logic [15:0] y, input logic [7:0] m);
        logic [39:0] p;
        logic [39:0] nw;
        p = $signed(x) * $signed(y);
        if (m[1])
            p = p << 1;
        nw = m[0] ? p : m_acc + p;
        if (!m[0] && ((m_acc[39:32] == 8'h7F && nw[39:32] == 8'h80)
            || (m_acc[39:32] == 8'h80 && nw[39:32] == 8'h7F)))
            m_sta[3] = 1'b1;
        m_sta[2:0] = {nw == 40'h0, nw[39:31] != {9{nw[39]}}, nw[39]};
        m_acc = nw;
        m_rnd = f_rnd(nw, m_sat);
    endtask

    task automatic mac(input logic [15:0] x, input logic [15:0] y, input logic [7:0] m);
        set_cfg(m);
        wr(`MACE_ADDR_OPA_HIGH, x[15:8]);
        wr(`MACE_ADDR_OPA_LOW, x[7:0]);
        wr(`MACE_ADDR_OPB_HIGH, y[15:8]);
        wr(`MACE_ADDR_OPB_LOW, y[7:0]);
        step(x, y, m);
    endtask

    task automatic shift(input logic right);
        set_cfg({3'b001, right, 4'h0});
        m_acc = right ? {m_acc[39], m_acc[39:1]} : m_acc << 1;
        m_rnd = f_rnd(m_acc, m_sat);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        err_count = 0;
        cmp_count = 0;
        seed = 32'h76fb;
        m_acc = 40'h0;
        m_sta = 4'h4;
        m_rnd = 16'h0;
        m_sat = 1'b0;
        rt = '{{1'b0, 40'h0012348001}, {1'b0, 40'h0012347FFF}, {1'b0, 40'h0012358000},
               {1'b0, 40'h0012348000}, {1'b1, 40'h007FFF8001}, {1'b0, 40'h007FFF8001},
               {1'b1, 40'hFF7FFF0000}};
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        check_all(1);
        rdchk("config", `MACE_ADDR_CONFIG, 8'h00);
        $display("test reset done");
        set_cfg(8'hC6);
        rdchk("config", `MACE_ADDR_CONFIG, 8'h06);
        wr(`MACE_ADDR_STATUS, 8'hF0);
        m_sta = 4'h0;
        rdchk("status", `MACE_ADDR_STATUS, 8'h00);
        wr(`MACE_ADDR_RND_HIGH, 8'h55);
        rdchk("rounding high", `MACE_ADDR_RND_HIGH, 8'h00);
        rdchk("unmapped", 8'h00, 8'h00);
        wr(`MACE_ADDR_OPA_LOW, 8'hA5);
        rdchk("operand", `MACE_ADDR_OPA_LOW, 8'hA5);
        $display("test access done");
        for (int i = 0; i < 7; i++) begin
            set_cfg({5'h0, rt[i][40], 2'b00});
            set_acc(rt[i][39:0]);
            wait_idle();
            check_all(1);
        end
        $display("test rounding done");
        set_acc(40'h4088442211);
        shift(1'b0);
        wait_idle();
        check_all(1);
        rdchk("config", `MACE_ADDR_CONFIG, 8'h00);
        shift(1'b1);
        shift(1'b1);
        wait_idle();
        check_all(1);
        rdchk("config", `MACE_ADDR_CONFIG, 8'h10);
        $display("test shift done");
        set_cfg(8'h00);
        set_acc(40'h7FFFFF0000);
        mac(16'h0100, 16'h0100, 8'h00);
        wait_idle();
        check_all(1);
        mac(16'h0002, 16'h0003, 8'h01);
        wait_idle();
        check_all(1);
        wr(`MACE_ADDR_STATUS, 8'h00);
        m_sta = 4'h0;
        mac(16'hFFFF, 16'h0001, 8'h01);
        wait_idle();
        set_cfg(8'h08);
        m_acc = 40'h0;
        m_sta = 4'h0;
        wait_idle();
        check_all(0);
        rdchk("config", `MACE_ADDR_CONFIG, 8'h00);
        $display("test overflow and clear done");
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            a = seed[15:0];
            c = {5'h0, seed[18:16]};
            seed = xs(seed);
            b = seed[15:0];
            mac(a, b, c);
            if (seed[20]) begin
                wr(`MACE_ADDR_OPB_LOW, seed[31:24]);
                step(a, {b[15:8], seed[31:24]}, c);
            end
            wait_idle();
            check_all(1);
        end
        $display("test random done");
        final_report();
    end
endmodule

// >>> mace_map.svh
/*
 * mace_map.svh
 * holds register addresses, field positions, reset values and constants
 * of the multiply-accumulate engine.
 * assumes inclusion by its bare name from the package and the engine.
 */
`ifndef MACE_MAP_SVH
`define MACE_MAP_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define MACE_ADDR_STATUS     8'hC0
`define MACE_ADDR_OPA_LOW    8'hC1
`define MACE_ADDR_OPA_HIGH   8'hC2
`define MACE_ADDR_CONFIG     8'hC3
`define MACE_ADDR_OPB_LOW    8'h91
`define MACE_ADDR_OPB_HIGH   8'h92
`define MACE_ADDR_ACC0       8'h93
`define MACE_ADDR_ACC1       8'h94
`define MACE_ADDR_ACC2       8'h95
`define MACE_ADDR_ACC3       8'h96
`define MACE_ADDR_GUARD      8'h97
`define MACE_ADDR_RND_LOW    8'hCE
`define MACE_ADDR_RND_HIGH   8'hCF

// ----------------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------------
`define MACE_CF_SHIFT_TRIG   5
`define MACE_CF_SHIFT_DIR    4
`define MACE_CF_CLEAR        3
`define MACE_CF_SAT          2
`define MACE_CF_FRAC         1
`define MACE_CF_MUL_ONLY     0
`define MACE_CF_MASK         8'h3F
`define MACE_CF_RESET        8'h00

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define MACE_ST_HARD_OVF     3
`define MACE_ST_ZERO         2
`define MACE_ST_SOFT_OVF     1
`define MACE_ST_NEG          0
`define MACE_ST_MASK         8'h0F
`define MACE_ST_RESET        8'h04
`define MACE_ST_CLEARED      4'h0

// ----------------------------------------------------------------------
// datapath constants
// ----------------------------------------------------------------------
`define MACE_ACC_W           40
`define MACE_ROUND_HALF      16'h8000
`define MACE_SAT_POS         16'h7FFF
`define MACE_SAT_NEG         16'h8000
`define MACE_GUARD_POS_MAX   8'h7F
`define MACE_GUARD_NEG_MIN   8'h80

`endif

// >>> mace_pkg.sv
/*
 * mace_pkg.sv
 * holds the state type of the multiply-accumulate engine.
 * assumes mace_map.svh is on the include path.
 */
`include "mace_map.svh"

package mace_pkg;

    // ------------------------------------------------------------------
    // whole engine state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0]  cfg;
        logic [3:0]  sta;
        logic [15:0] opa;
        logic [15:0] opb;
        logic [39:0] acc;
        logic [15:0] rnd;
        logic [31:0] prod;
        logic        st1;
        logic        st2;
        logic        rnd_pend;
        logic        ms_1;
        logic        fm_1;
        logic        ms_2;
        logic        fm_2;
        logic [7:0]  rdata;
    } mace_state_t;

endpackage
